// *** hdl/uef_top.sv ***
// Summary of operation
// - Status-complete bit 2 sets when the endpoint-0 status stage ends successfully.
// - Status-arrival bit 1 sets when a status-stage packet arrives in a control read.
// - An IN token after a zero-length close of a 64-byte-multiple write sets bit 1 too.
// - Setup-received bit 0 sets on every SETUP token for endpoint 0.
// - Endpoints 1 to 7 each own a completion flag in bits 1 to 7, set on success.
// - A completion flag reads 0 until data moved on that endpoint, then 1.
// - A per-endpoint mask register picks which flags reach the endpoint interrupt.
// - Mask 0 passes, 1 blocks but the flag still sets; mask bit 0 is unused here.
// - Writing 1 to the summary endpoint bit clears all completion flags.
module uef_top
   import uef_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic [REG_AW-1:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire logic setup_tok_i,
   input wire logic status_pkt_i,
   input wire logic in_tok_after_zlp_i,
   input wire logic status_ok_i,
   input wire logic [7:1] ep_done_i,
   output logic endpoint_irq_out_o,
   output logic irq_o
);
   uef_evt_if ep0_ev ();
   uef_evt_if ep_ev ();

   logic [7:0] endpoint_mask_bits_r;
   logic [7:0] int_mask_r;
   logic [3:0] irq_stat_r;
   logic [3:0] irq_mask_r;
   logic [7:0] ep0_flags;
   logic [7:0] ep_flags;
   logic [7:1] ep_gated;
   logic ep_sum;
   logic [3:0] irq_evt;
   logic wr_status;
   logic wr_done;

   // Offsets reach 0x10, so the address needs five bits
   if (REG_AW < 5) begin : g_aw_check
      $error("register address too narrow");
   end

   function automatic logic hit(input logic [REG_AW-1:0] a, input logic [REG_AW-1:0] ofs);
      hit = (a == ofs);
   endfunction

   assign wr_status = wr_i && hit(addr_i, OFS_INT_STATUS);
   assign wr_done = wr_i && hit(addr_i, OFS_EP_DONE);

   // Endpoint-0 stage events
   always_comb begin
      ep0_ev.set = 8'h00;
      ep0_ev.set[BIT_SETUP] = setup_tok_i;
      ep0_ev.set[BIT_STATUS_NAK] = status_pkt_i | in_tok_after_zlp_i;
      ep0_ev.set[BIT_STATUS] = status_ok_i;
      ep0_ev.clr = wr_status ? {5'h00, wdata_i[2:0]} : 8'h00;
   end

   uef_sticky u_ep0 (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .ev(ep0_ev.owner)
   );
   assign ep0_flags = ep0_ev.flags;

   // Completion flags; summary write clears all, per-bit write also clears
   always_comb begin
      ep_ev.set = {ep_done_i, 1'b0};
      ep_ev.clr = 8'h00;
      if (wr_status && wdata_i[BIT_EP_SUM]) begin
         ep_ev.clr = 8'hfe;
      end else if (wr_done) begin
         ep_ev.clr = {wdata_i[7:1], 1'b0};
      end
   end

   uef_sticky u_ep (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .ev(ep_ev.owner)
   );
   assign ep_flags = ep_ev.flags;

   // Bit 0 of the mask does not gate completion flags
   for (genvar g = 1; g < 8; g++) begin : g_gate
      assign ep_gated[g] = ep_flags[g] & ~endpoint_mask_bits_r[g];
   end
   assign ep_sum = |ep_gated;

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         endpoint_mask_bits_r <= RST_EP_MASK;
      end else if (wr_i && hit(addr_i, OFS_EP_MASK)) begin
         endpoint_mask_bits_r <= wdata_i[7:0];
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         int_mask_r <= RST_INT_MASK;
      end else if (wr_status) begin
         int_mask_r <= wdata_i[15:8];
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         endpoint_irq_out_o <= 1'b0;
      end else begin
         endpoint_irq_out_o <= ep_sum && !int_mask_r[BIT_M_EP_SUM-8];
      end
   end

   // Stage events and the endpoint summary, sticky, write-one-to-clear
   assign irq_evt = {ep_sum, ep0_ev.set[2:0]};

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_stat_r <= 4'h0;
      end else begin
         irq_stat_r <= (irq_stat_r & ~((wr_i && hit(addr_i, OFS_IRQ_STAT)) ? wdata_i[3:0] : 4'h0))
            | irq_evt;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_mask_r <= RST_IRQ_MASK;
      end else if (wr_i && hit(addr_i, OFS_IRQ_MASK)) begin
         irq_mask_r <= wdata_i[3:0];
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_stat_r & irq_mask_r);
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_o <= 32'h0000_0000;
      end else if (rd_i) begin
         unique case (addr_i)
            OFS_INT_STATUS: rdata_o <= {16'h0000, int_mask_r, 1'b0, ep_sum, 3'h0, ep0_flags[2:0]};
            OFS_EP_DONE: rdata_o <= {24'h000000, ep_flags[7:1], 1'b0};
            OFS_EP_MASK: rdata_o <= {24'h000000, endpoint_mask_bits_r};
            OFS_IRQ_STAT: rdata_o <= {28'h0000000, irq_stat_r};
            OFS_IRQ_MASK: rdata_o <= {28'h0000000, irq_mask_r};
            default: rdata_o <= 32'h0000_0000;
         endcase
      end else begin
         rdata_o <= 32'h0000_0000;
      end
   end

   property p_setup_flag;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
         setup_tok_i |=> ep0_flags[BIT_SETUP];
   endproperty
   a_setup_flag: assert property (p_setup_flag) else $error("setup flag not set");

   property p_status_nak;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
         (status_pkt_i || in_tok_after_zlp_i) |=> ep0_flags[BIT_STATUS_NAK];
   endproperty
   a_status_nak: assert property (p_status_nak) else $error("status arrival lost");

   property p_status_ok;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
         status_ok_i |=> ep0_flags[BIT_STATUS];
   endproperty
   a_status_ok: assert property (p_status_ok) else $error("status done lost");

   property p_ep_set;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
         ep_done_i[3] |=> ep_flags[3];
   endproperty
   a_ep_set: assert property (p_ep_set) else $error("ep flag lost");

   property p_ep_hold;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
         (ep_flags[5] && !wr_status && !wr_done) |=> ep_flags[5];
   endproperty
   a_ep_hold: assert property (p_ep_hold) else $error("ep flag dropped");

   property p_sum_clear;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
         (wr_status && wdata_i[BIT_EP_SUM] && ep_done_i == 7'h00) |=> ep_flags[7:1] == 7'h00;
   endproperty
   a_sum_clear: assert property (p_sum_clear) else $error("summary clear failed");

   sequence s_masked_done;
      endpoint_mask_bits_r[2] && ep_flags[2] && ep_flags[7:3] == 5'h00 && !ep_flags[1];
   endsequence
   property p_mask_block;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
         s_masked_done |=> !endpoint_irq_out_o;
   endproperty
   a_mask_block: assert property (p_mask_block) else $error("masked ep raised irq");

   property p_irq_follow;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
         (ep_sum && !int_mask_r[BIT_M_EP_SUM-8]) |=> endpoint_irq_out_o;
   endproperty
   a_irq_follow: assert property (p_irq_follow) else $error("ep irq missing");

   property p_mask_write;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
         (wr_i && addr_i == OFS_EP_MASK) |=> endpoint_mask_bits_r == $past(wdata_i[7:0]);
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("mask not stored");

   property p_setup_w1c;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
         (wr_status && wdata_i[BIT_SETUP] && !setup_tok_i) |=> !ep0_flags[BIT_SETUP];
   endproperty
   a_setup_w1c: assert property (p_setup_w1c) else $error("setup flag not cleared");

   property p_setup_wins;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
         (setup_tok_i && wr_status && wdata_i[BIT_SETUP]) |=> ep0_flags[BIT_SETUP];
   endproperty
   a_setup_wins: assert property (p_setup_wins) else $error("clear beat setup");

   property p_status_hold;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
         (ep0_flags[BIT_STATUS] && !(wr_status && wdata_i[BIT_STATUS])) |=> ep0_flags[BIT_STATUS];
   endproperty
   a_status_hold: assert property (p_status_hold) else $error("status done dropped");

   property p_status_w1c;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
         (wr_status && wdata_i[BIT_STATUS] && !status_ok_i) |=> !ep0_flags[BIT_STATUS];
   endproperty
   a_status_w1c: assert property (p_status_w1c) else $error("status not cleared");

   sequence s_arrival_kept;
      status_pkt_i ##1 !(wr_status && wdata_i[BIT_STATUS_NAK]);
   endsequence

   property p_arrival_kept;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
         s_arrival_kept |=> ep0_flags[BIT_STATUS_NAK];
   endproperty
   a_arrival_kept: assert property (p_arrival_kept) else $error("arrival dropped");

   property p_zlp_in;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
         in_tok_after_zlp_i |=> ep0_flags[BIT_STATUS_NAK] && irq_stat_r[BIT_STATUS_NAK];
   endproperty
   a_zlp_in: assert property (p_zlp_in) else $error("in token lost");

   property p_ep_set_all;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
         (ep_done_i != 7'h00) |=> (ep_flags[7:1] & $past(ep_done_i)) == $past(ep_done_i);
   endproperty
   a_ep_set_all: assert property (p_ep_set_all) else $error("ep flags lost");

   property p_ep_w1c;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
         (wr_done && wdata_i[4] && !ep_done_i[4]) |=> !ep_flags[4];
   endproperty
   a_ep_w1c: assert property (p_ep_w1c) else $error("ep flag not cleared");

   property p_ep_other_kept;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
         (ep_flags[6] && wr_done && !wdata_i[6]) |=> ep_flags[6];
   endproperty
   a_ep_other_kept: assert property (p_ep_other_kept) else $error("wrong ep cleared");

   property p_mask_stable;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
         !(wr_i && addr_i == OFS_EP_MASK) |=> $stable(endpoint_mask_bits_r);
   endproperty
   a_mask_stable: assert property (p_mask_stable) else $error("mask changed");

   property p_mask_no_irq;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
         (ep_gated == 7'h00) |=> !endpoint_irq_out_o;
   endproperty
   a_mask_no_irq: assert property (p_mask_no_irq) else $error("irq without cause");

   property p_masked_sets;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
         (endpoint_mask_bits_r[2] && ep_done_i[2]) |=> ep_flags[2];
   endproperty
   a_masked_sets: assert property (p_masked_sets) else $error("masked flag lost");

   sequence s_sum_wipe;
      (wr_status && wdata_i[BIT_EP_SUM] && ep_done_i == 7'h00) ##1 1'b1;
   endsequence

   property p_sum_wipe;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
         s_sum_wipe |=> !endpoint_irq_out_o;
   endproperty
   a_sum_wipe: assert property (p_sum_wipe) else $error("irq after wipe");

   property p_irq_gate;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
         int_mask_r[BIT_M_EP_SUM-8] |=> !endpoint_irq_out_o;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("gated irq raised");

   property p_rd_done;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
         (rd_i && addr_i == OFS_EP_DONE) |=> rdata_o == {24'h000000, $past(ep_flags[7:1]), 1'b0};
   endproperty
   a_rd_done: assert property (p_rd_done) else $error("done read wrong");

   property p_rd_idle;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
         !rd_i |=> rdata_o == 32'h0000_0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");

   property p_irq_stat_set;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
         status_ok_i |=> irq_stat_r[BIT_STATUS];
   endproperty
   a_irq_stat_set: assert property (p_irq_stat_set) else $error("irq status lost");

   property p_irq_o;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
         (|(irq_stat_r & irq_mask_r)) |=> irq_o;
   endproperty
   a_irq_o: assert property (p_irq_o) else $error("irq missing");

   property p_irq_o_low;
      @(posedge sys_clk_i) disable iff (!rst_b_i)
         !(|(irq_stat_r & irq_mask_r)) |=> !irq_o;
   endproperty
   a_irq_o_low: assert property (p_irq_o_low) else $error("irq without cause");
endmodule

// *** hdl/uef_pkg.sv ***
package uef_pkg;
   localparam int REG_AW = 5;
   localparam logic [REG_AW-1:0] OFS_INT_STATUS = 5'h00;
   localparam logic [REG_AW-1:0] OFS_EP_DONE = 5'h04;
   localparam logic [REG_AW-1:0] OFS_EP_MASK = 5'h08;
   localparam logic [REG_AW-1:0] OFS_IRQ_STAT = 5'h0c;
   localparam logic [REG_AW-1:0] OFS_IRQ_MASK = 5'h10;
   localparam int BIT_SETUP = 0;
   localparam int BIT_STATUS_NAK = 1;
   localparam int BIT_STATUS = 2;
   localparam int BIT_EP_SUM = 6;
   localparam int BIT_M_SETUP = 8;
   localparam int BIT_M_STATUS_NAK = 9;
   localparam int BIT_M_STATUS = 10;
   localparam int BIT_M_EP_SUM = 14;
   localparam logic [7:0] RST_EP_MASK = 8'h00;
   localparam logic [7:0] RST_INT_MASK = 8'h00;
   localparam logic [3:0] RST_IRQ_MASK = 4'h0;
   localparam int N_IRQ = 4;
endpackage

// *** hdl/uef_evt_if.sv ***
interface uef_evt_if;
   logic [7:0] set;
   logic [7:0] clr;
   logic [7:0] flags;
   modport owner (input set, input clr, output flags);
   modport user (output set, output clr, input flags);
endinterface

// *** hdl/uef_sticky.sv ***
module uef_sticky
   import uef_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   uef_evt_if.owner ev
);
   logic [7:0] flag_r;

   // Set wins over a clear in the same cycle
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         flag_r <= 8'h00;
      end else begin
         flag_r <= (flag_r & ~ev.clr) | ev.set;
      end
   end

   assign ev.flags = flag_r;
endmodule

// *** sim/uef_host.sv ***
module uef_host (
   input wire logic sys_clk_i,
   output logic setup_tok_o,
   output logic status_pkt_o,
   output logic in_tok_o,
   output logic status_ok_o,
   output logic [7:1] ep_done_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {ep_done_o, status_ok_o, in_tok_o, status_pkt_o, setup_tok_o} = 11'h000;
   end
   // One-cycle token or handshake; in_tok follows a zero-length close
   task automatic fire(input logic [10:0] ev);
      @(posedge sys_clk_i);
      {ep_done_o, status_ok_o, in_tok_o, status_pkt_o, setup_tok_o} <= ev;
      @(posedge sys_clk_i);
      {ep_done_o, status_ok_o, in_tok_o, status_pkt_o, setup_tok_o} <= 11'h000;
   endtask
endmodule

// *** sim/tb.sv ***
module tb
   import uef_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [REG_AW-1:0] addr = 5'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic ep_irq;
   logic irq;
   wire logic setup_tok, status_pkt, in_tok, status_ok;
   wire logic [7:1] ep_done;
   int num_errors = 0;
   int num_checks = 0;
   logic [31:0] exp;

   uef_host host (.sys_clk_i(sys_clk_i), .setup_tok_o(setup_tok), .status_pkt_o(status_pkt),
      .in_tok_o(in_tok), .status_ok_o(status_ok), .ep_done_o(ep_done));
   uef_top uut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .setup_tok_i(setup_tok),
      .status_pkt_i(status_pkt), .in_tok_after_zlp_i(in_tok), .status_ok_i(status_ok),
      .ep_done_i(ep_done), .endpoint_irq_out_o(ep_irq), .irq_o(irq));

   initial begin
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      num_checks++;
      if (got !== want) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask

   task automatic wr_reg(input logic [REG_AW-1:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk_i);
      wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [REG_AW-1:0] a, input logic [31:0] want);
      @(posedge sys_clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk_i);
      rd <= 1'b0;
      #1 chk(rdata, want);
   endtask

   task automatic report_and_stop();
      if (num_errors == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge sys_clk_i);
      num_errors++;
      report_and_stop();
   end

   initial begin
      repeat (10) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      rd_chk(OFS_INT_STATUS, 32'h0);
      rd_chk(OFS_EP_DONE, 32'h0);
      rd_chk(OFS_EP_MASK, 32'h0);
      rd_chk(5'h02, 32'h0);
      chk({31'h0, ep_irq}, 32'h0);
      // Each endpoint-0 event lands on its flag; status packet and IN token share bit 1
      for (int i = 0; i < 4; i++) begin
         exp = (i == 0) ? 32'h1 : (i == 3) ? 32'h4 : 32'h2;
         host.fire(11'h001 << i);
         rd_chk(OFS_INT_STATUS, exp);
         wr_reg(OFS_INT_STATUS, 32'h7); // Clear before advancing the stage
         rd_chk(OFS_INT_STATUS, 32'h0);
      end
      for (int n = 1; n < 8; n++) begin
         host.fire(11'h008 << n);
         rd_chk(OFS_EP_DONE, 32'h1 << n);
         chk({31'h0, ep_irq}, 32'h1);
         wr_reg(OFS_EP_DONE, 32'h1 << n);
         rd_chk(OFS_EP_DONE, 32'h0);
         chk({31'h0, ep_irq}, 32'h0);
      end
      wr_reg(OFS_EP_MASK, 32'h4);
      host.fire(11'h020);
      rd_chk(OFS_EP_DONE, 32'h4);
      chk({31'h0, ep_irq}, 32'h0);
      rd_chk(OFS_INT_STATUS, 32'h0);
      rd_chk(OFS_EP_MASK, 32'h4);
      wr_reg(OFS_EP_MASK, 32'h0);
      rd_chk(OFS_INT_STATUS, 32'h40);
      chk({31'h0, ep_irq}, 32'h1);
      host.fire(11'h100);
      rd_chk(OFS_EP_DONE, 32'h24);
      // Summary write-one wipes every endpoint flag; mask bit 14 in the same write blocks the output
      wr_reg(OFS_INT_STATUS, 32'h4040);
      rd_chk(OFS_EP_DONE, 32'h0);
      host.fire(11'h040);
      rd_chk(OFS_INT_STATUS, 32'h4040);
      chk({31'h0, ep_irq}, 32'h0);
      wr_reg(OFS_INT_STATUS, 32'h40);
      rd_chk(OFS_EP_DONE, 32'h0);
      chk({31'h0, ep_irq}, 32'h0);
      // Stage interrupt status and its enable mask drive irq_o
      wr_reg(OFS_IRQ_STAT, 32'hf);
      rd_chk(OFS_IRQ_STAT, 32'h0);
      wr_reg(OFS_IRQ_MASK, 32'h1);
      rd_chk(OFS_IRQ_MASK, 32'h1);
      chk({31'h0, irq}, 32'h0);
      host.fire(11'h001);
      rd_chk(OFS_IRQ_STAT, 32'h1);
      chk({31'h0, irq}, 32'h1);
      wr_reg(OFS_IRQ_STAT, 32'h1);
      rd_chk(OFS_IRQ_STAT, 32'h0);
      chk({31'h0, irq}, 32'h0);
      report_and_stop();
   end
endmodule
